// [core/flash_pkg.sv]
// Constants shared by the flash command and protection block
package flash_pkg;
	// Register byte addresses on the APB
	localparam logic [7:0] OFS_PROT = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_ADDR = 8'h10;
	localparam logic [7:0] OFS_DATA = 8'h14;
	localparam logic [7:0] OFS_ISTAT = 8'h18;
	localparam logic [7:0] OFS_ICLR = 8'h1c;
	localparam logic [7:0] OFS_IEN = 8'h20;
	localparam logic [7:0] OFS_SEC = 8'h24;
	// Status register fields
	localparam int unsigned BIT_CBEF = 7;
	localparam int unsigned BIT_CCF = 6;
	localparam int unsigned BIT_PVIOL = 5;
	localparam int unsigned BIT_ACCERR = 4;
	localparam int unsigned BIT_BLANK = 2;
	// Protection register fields
	localparam int unsigned BIT_PDIS = 0;
	localparam int unsigned PROT_PAGE_BITS = 9;
	// Control register: divider configured flag
	localparam int unsigned BIT_DIV_READY = 0;
	// Interrupt status, clear and enable layout
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_PVIOL = 1;
	localparam int unsigned IRQ_ACCERR = 2;
	// Command codes
	localparam logic [7:0] CMD_BLANK = 8'h05;
	localparam logic [7:0] CMD_BYTE = 8'h20;
	localparam logic [7:0] CMD_BURST = 8'h25;
	localparam logic [7:0] CMD_PAGE = 8'h40;
	localparam logic [7:0] CMD_MASS = 8'h41;
	// Reset values and the unsecured security code
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] PROT_RESET = 8'h00;
	localparam logic [1:0] SEC_RESET = 2'h0;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	// Operation times in ns and derived cycle counts at 20 MHz
	localparam int unsigned CLK_NS = 50;
	localparam int unsigned BLANK_NS = 100000;
	localparam int unsigned BYTE_PROG_NS = 45000;
	localparam int unsigned BURST_PROG_NS = 20000;
	localparam int unsigned PAGE_ERASE_NS = 20000000;
	localparam int unsigned MASS_ERASE_NS = 100000000;
	localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BYTE_PROG_CYC = (BYTE_PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BURST_PROG_CYC = (BURST_PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PAGE_ERASE_CYC = (PAGE_ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned MASS_ERASE_CYC = (MASS_ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CNT_W = 22;
	// Launch sequence progress
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} seq_e;
endpackage

// [core/flash_op_engine.sv]
// Array operation timer: runs one command for its fixed duration
`timescale 1ns/1ps
`default_nettype none
module flash_op_engine
	import flash_pkg::*;
#(
	parameter int unsigned PAGE_CYC = flash_pkg::PAGE_ERASE_CYC,
	parameter int unsigned MASS_CYC = flash_pkg::MASS_ERASE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [7:0] cmd,
	input wire logic abort,
	output logic busy,
	output logic done
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] load_cnt;

	// Duration per command; unknown codes never reach here
	always_comb begin
		case (cmd)
			CMD_BLANK: load_cnt = CNT_W'(BLANK_CYC);
			CMD_BYTE: load_cnt = CNT_W'(BYTE_PROG_CYC);
			CMD_BURST: load_cnt = CNT_W'(BURST_PROG_CYC);
			CMD_PAGE: load_cnt = CNT_W'(PAGE_CYC);
			CMD_MASS: load_cnt = CNT_W'(MASS_CYC);
			default: load_cnt = CNT_W'(1);
		endcase
	end

	// Countdown; abort (stop entry) wins over everything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			cnt <= '0;
		end else if (abort) begin
			busy <= 1'b0;
			cnt <= '0;
		end else if (start) begin
			busy <= 1'b1;
			cnt <= load_cnt;
		end else if (busy) begin
			if (cnt == CNT_W'(1))
				busy <= 1'b0;
			cnt <= cnt - CNT_W'(1);
		end
	end

	// One-cycle completion pulse, suppressed by an abort
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			done <= 1'b0;
		else
			done <= busy && cnt == CNT_W'(1) && !abort;
	end

	property p_start_busy;
		@(posedge pclk) disable iff (!presetn)
		start && !abort |=> busy;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("engine not busy after start");

	property p_done_idle;
		@(posedge pclk) disable iff (!presetn)
		done |-> !busy;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("done while busy");
endmodule // flash_op_engine
`default_nettype wire

// [core/flash_protect_status_cmd.sv]
// Flash protection, status and command registers over APB
`timescale 1ns/1ps
`default_nettype none
module flash_protect_status_cmd
	import flash_pkg::*;
#(
	parameter int unsigned PAGE_CYC = flash_pkg::PAGE_ERASE_CYC,
	parameter int unsigned MASS_CYC = flash_pkg::MASS_ERASE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] nonvolatile_protection_byte,
	input wire logic [1:0] nonvolatile_security_code,
	input wire logic debug_prot_write,
	input wire logic [7:0] debug_prot_data,
	input wire logic stop_entry,
	input wire logic array_blank,
	output logic [1:0] security_state_code,
	output logic irq
);
	// Register state, decoded strobes and engine handshake
	logic loaded, command_buffer_empty_flag, command_complete_flag, protection_violation_flag;
	logic access_error_flag, blank_verified_flag, div_ready, pending;
	logic [7:0] protection_register, command_register, pend_cmd, run_cmd;
	logic [15:0] target_addr, unprot_end;
	logic [IRQ_W-1:0] irq_status, irq_enable;
	seq_e seq;
	logic setup, wr, mapped, stat_wr, cmd_wr, data_wr, prot_wr, cmd_legal, prot_hit;
	logic launch_req, launch_ok, acc_set, pviol_set, blank_ok;
	logic [31:0] rd_mux;
	logic eng_busy, eng_done, eng_start, eng_abort;

	// APB phases; a write takes effect only in the access cycle
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite && pready;
	assign stat_wr = wr && paddr == OFS_STAT;
	assign cmd_wr = wr && paddr == OFS_CMD;
	assign data_wr = wr && paddr == OFS_DATA;
	assign prot_wr = wr && paddr == OFS_PROT;
	// Address decode; anything else answers with an error and has no effect
	assign mapped = paddr inside {OFS_PROT, OFS_STAT, OFS_CMD, OFS_CTRL, OFS_ADDR, OFS_DATA,
		OFS_ISTAT, OFS_ICLR, OFS_IEN, OFS_SEC};

	// Read mux; write-only registers read as zero
	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			OFS_PROT: rd_mux[7:0] = protection_register;
			OFS_STAT: begin
				rd_mux[BIT_CBEF] = command_buffer_empty_flag;
				rd_mux[BIT_CCF] = command_complete_flag;
				rd_mux[BIT_PVIOL] = protection_violation_flag;
				rd_mux[BIT_ACCERR] = access_error_flag;
				rd_mux[BIT_BLANK] = blank_verified_flag; // bits 3,1,0 stay zero
			end
			OFS_CTRL: rd_mux[BIT_DIV_READY] = div_ready;
			OFS_ADDR: rd_mux[15:0] = target_addr;
			OFS_ISTAT: rd_mux[IRQ_W-1:0] = irq_status;
			OFS_IEN: rd_mux[IRQ_W-1:0] = irq_enable;
			OFS_SEC: rd_mux[1:0] = security_state_code;
			default: rd_mux = 32'h0; // command register reads zero
		endcase
	end
	// No wait state: answer is registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
			pslverr <= setup && !mapped;
		end
	end
	// Legal codes and protection check
	always_comb begin
		case (pwdata[7:0])
			CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS: cmd_legal = 1'b1;
			default: cmd_legal = 1'b0;
		endcase
	end
	assign unprot_end = {protection_register[7:1], {PROT_PAGE_BITS{1'b1}}};
	always_comb begin
		prot_hit = 1'b0;
		if (!protection_register[BIT_PDIS]) begin
			case (command_register)
				CMD_MASS: prot_hit = 1'b1;
				CMD_BYTE, CMD_BURST, CMD_PAGE: prot_hit = target_addr > unprot_end;
				default: prot_hit = 1'b0;
			endcase
		end
	end
	// Launch qualification; blank check never touches protection
	assign launch_req = stat_wr && pwdata[BIT_CBEF];
	always_comb begin
		acc_set = 1'b0;
		pviol_set = 1'b0;
		launch_ok = 1'b0;
		if (stop_entry && (eng_busy || pending))
			acc_set = 1'b1;
		if (cmd_wr && (seq != SEQ_DATA || !cmd_legal))
			acc_set = 1'b1;
		if (data_wr && (seq == SEQ_CMD || !command_buffer_empty_flag))
			acc_set = 1'b1;
		if (launch_req) begin
			if (seq != SEQ_CMD || !command_buffer_empty_flag || !div_ready)
				acc_set = 1'b1;
			else if (command_register != CMD_BURST && (eng_busy || pending))
				acc_set = 1'b1;
			else if (prot_hit)
				pviol_set = 1'b1;
			else if (!stop_entry)
				launch_ok = 1'b1;
		end
	end
	// Launch sequence tracking; any step out of order restarts it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			seq <= SEQ_IDLE;
		else if (launch_req || acc_set)
			seq <= SEQ_IDLE;
		else if (data_wr)
			seq <= SEQ_DATA;
		else if (cmd_wr)
			seq <= SEQ_CMD;
	end
	// Command and address capture; command register clears after launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			command_register <= CMD_RESET;
			target_addr <= 16'h0;
		end else begin
			if (cmd_wr && seq == SEQ_DATA && cmd_legal)
				command_register <= pwdata[7:0];
			else if (launch_req)
				command_register <= CMD_RESET;
			if (wr && paddr == OFS_ADDR)
				target_addr <= pwdata[15:0];
		end
	end
	// Protection register: strap load after reset release, then guarded writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded <= 1'b0;
			protection_register <= PROT_RESET;
		end else if (!loaded) begin
			loaded <= 1'b1;
			protection_register <= nonvolatile_protection_byte;
		end else if (debug_prot_write) begin
			protection_register <= debug_prot_data;
		end else if (prot_wr && !protection_register[BIT_PDIS]) begin
			if (pwdata[7:1] < protection_register[7:1])
				protection_register[7:1] <= pwdata[7:1];
		end // disabled: writes ignored
	end
	// Divider-ready control and interrupt enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ready <= 1'b0;
			irq_enable <= '0;
		end else begin
			if (wr && paddr == OFS_CTRL)
				div_ready <= pwdata[BIT_DIV_READY];
			if (wr && paddr == OFS_IEN)
				irq_enable <= pwdata[IRQ_W-1:0];
		end
	end
	// Single-entry buffer feeding the engine; stop entry flushes it
	assign eng_abort = stop_entry && (eng_busy || pending);
	assign eng_start = pending && !eng_busy && !eng_abort;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= 1'b0;
			pend_cmd <= CMD_RESET;
			run_cmd <= CMD_RESET;
		end else if (eng_abort) begin
			pending <= 1'b0;
		end else if (launch_ok) begin
			pending <= 1'b1;
			pend_cmd <= command_register;
		end else if (eng_start) begin
			pending <= 1'b0;
			run_cmd <= pend_cmd;
		end
	end
	flash_op_engine #(
		.PAGE_CYC(PAGE_CYC),
		.MASS_CYC(MASS_CYC)
	) flash_op_engine_inst (
		.pclk(pclk),
		.presetn(presetn),
		.start(eng_start),
		.cmd(pend_cmd),
		.abort(eng_abort),
		.busy(eng_busy),
		.done(eng_done)
	);

	// Buffer-empty: cleared by launch, set when the buffer moves to the array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			command_buffer_empty_flag <= 1'b1;
		else if (launch_ok)
			command_buffer_empty_flag <= 1'b0;
		else if (eng_start || eng_abort)
			command_buffer_empty_flag <= 1'b1;
	end

	// Complete flag follows idleness; writes never reach it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			command_complete_flag <= 1'b1;
		else if (launch_ok)
			command_complete_flag <= 1'b0;
		else
			command_complete_flag <= !pending && !eng_busy;
	end

	// Error flags: hardware set wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			protection_violation_flag <= 1'b0;
			access_error_flag <= 1'b0;
		end else begin
			if (pviol_set)
				protection_violation_flag <= 1'b1;
			else if (stat_wr && pwdata[BIT_PVIOL])
				protection_violation_flag <= 1'b0;
			if (acc_set)
				access_error_flag <= 1'b1;
			else if (stat_wr && pwdata[BIT_ACCERR])
				access_error_flag <= 1'b0;
		end
	end

	// Blank result and the unlock it grants
	assign blank_ok = eng_done && run_cmd == CMD_BLANK && array_blank;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_verified_flag <= 1'b0;
			security_state_code <= SEC_RESET;
		end else begin
			if (blank_ok)
				blank_verified_flag <= 1'b1;
			else if (launch_ok)
				blank_verified_flag <= 1'b0;
			if (!loaded)
				security_state_code <= nonvolatile_security_code;
			else if (blank_ok)
				security_state_code <= SEC_UNSECURED;
		end
	end

	// Sticky interrupt causes; a clear in the same cycle loses to the event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~((wr && paddr == OFS_ICLR) ? pwdata[IRQ_W-1:0] : '0))
				| {acc_set, pviol_set, eng_done};
			irq <= |(irq_status & irq_enable);
		end
	end

	// Checks
	sequence s_launch;
		launch_ok;
	endsequence
	sequence s_blank_pass;
		eng_done && run_cmd == CMD_BLANK && array_blank;
	endsequence
	property p_nv_load;
		@(posedge pclk) disable iff (!presetn)
		$rose(loaded) |-> protection_register == $past(nonvolatile_protection_byte);
	endproperty
	a_nv_load: assert property (p_nv_load) else $error("protection not loaded");
	property p_no_raise;
		@(posedge pclk) disable iff (!presetn)
		loaded && prot_wr && !debug_prot_write && !protection_register[BIT_PDIS]
			&& pwdata[7:1] >= protection_register[7:1] |=> $stable(protection_register);
	endproperty
	a_no_raise: assert property (p_no_raise) else $error("protection lowered");
	property p_locked;
		@(posedge pclk) disable iff (!presetn)
		loaded && prot_wr && !debug_prot_write && protection_register[BIT_PDIS]
			|=> $stable(protection_register);
	endproperty
	a_locked: assert property (p_locked) else $error("disabled protection changed");
	property p_stat_zero;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == OFS_STAT |=> prdata[3] == 1'b0 && prdata[1:0] == 2'h0;
	endproperty
	a_stat_zero: assert property (p_stat_zero) else $error("reserved status bit set");
	property p_launch;
		@(posedge pclk) disable iff (!presetn)
		s_launch |=> !command_complete_flag && !blank_verified_flag && pending;
	endproperty
	a_launch: assert property (p_launch) else $error("launch did not clear flags");
	property p_transfer;
		@(posedge pclk) disable iff (!presetn)
		s_launch ##1 !eng_busy && !stop_entry |=> command_buffer_empty_flag && eng_busy;
	endproperty
	a_transfer: assert property (p_transfer) else $error("buffer not transferred");
	property p_pviol;
		@(posedge pclk) disable iff (!presetn)
		pviol_set |=> protection_violation_flag && !pending ##1 protection_violation_flag || !stat_wr;
	endproperty
	a_pviol: assert property (p_pviol) else $error("violation not flagged");
	property p_acc_w0;
		@(posedge pclk) disable iff (!presetn)
		access_error_flag && !(stat_wr && pwdata[BIT_ACCERR]) |=> access_error_flag;
	endproperty
	a_acc_w0: assert property (p_acc_w0) else $error("access error lost");
	property p_illegal;
		@(posedge pclk) disable iff (!presetn)
		cmd_wr && !cmd_legal |=> access_error_flag && seq == SEQ_IDLE;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal code accepted");
	property p_cmd_zero;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == OFS_CMD |=> prdata == 32'h0;
	endproperty
	a_cmd_zero: assert property (p_cmd_zero) else $error("command register read nonzero");
	property p_blank_sec;
		@(posedge pclk) disable iff (!presetn)
		s_blank_pass |=> blank_verified_flag && security_state_code == SEC_UNSECURED;
	endproperty
	a_blank_sec: assert property (p_blank_sec) else $error("blank pass not recorded");
endmodule // flash_protect_status_cmd
`default_nettype wire

// [tb/flash_protect_status_cmd_bench.sv]
// Self-checking bench for the flash protection, status and command block
`timescale 1ns/1ps
`default_nettype none
module flash_protect_status_cmd_bench;
	import flash_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic debug_prot_write, stop_entry, array_blank;
	logic [7:0] paddr, debug_prot_data;
	logic [31:0] pwdata, prdata, rdata;
	logic [1:0] security_state_code;
	logic rerr;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] ta[8] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h81ff, 16'h8200, 16'h9000, 16'h0000};
	logic [7:0] tc[8] = '{CMD_BLANK, CMD_BLANK, CMD_BYTE, 8'h33, CMD_BURST, CMD_PAGE, CMD_BYTE, CMD_MASS};
	logic [31:0] te[8] = '{32'h40, 32'h44, 32'h40, 32'h50, 32'h40, 32'h60, 32'h60, 32'h60};

	// Short erase counts keep the run brief
	flash_protect_status_cmd #(.PAGE_CYC(20), .MASS_CYC(30)) flash_protect_status_cmd_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nonvolatile_protection_byte(8'ha0), .nonvolatile_security_code(2'h3),
		.debug_prot_write(debug_prot_write), .debug_prot_data(debug_prot_data),
		.stop_entry(stop_entry), .array_blank(array_blank),
		.security_state_code(security_state_code), .irq(irq)
	);

	always #25 pclk = ~pclk;

	// Cycle ceiling cuts a hang short
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		$display("counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One APB transfer; values read just after an edge are those that stood in the access cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
	endtask

	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		idle(1);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		idle(1);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report(input string s);
		$display("test %s finished, failures so far %0d", s, failures);
	endtask

	// Full launch: address, array write, command, then set the buffer-empty bit
	task automatic launch(input logic [15:0] a, input logic [7:0] c);
		apb(1'b1, OFS_ADDR, {16'h0, a});
		apb(1'b1, OFS_DATA, 32'h0);
		apb(1'b1, OFS_CMD, {24'h0, c});
		apb(1'b1, OFS_STAT, 32'h80);
		idle(1);
	endtask

	// Poll the complete flag; the count bounds the wait
	task automatic wait_done();
		int n;
		n = 0;
		rd(OFS_STAT);
		while (rdata[BIT_CCF] !== 1'b1 && n < 2000) begin
			rd(OFS_STAT);
			n++;
		end
	endtask

	// The debug port writes for exactly one cycle
	task automatic dbg(input logic [7:0] v);
		debug_prot_data <= v;
		debug_prot_write <= 1'b1;
		@(posedge pclk);
		debug_prot_write <= 1'b0;
		idle(1);
	endtask

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		debug_prot_write = 1'b0;
		debug_prot_data = 8'h00;
		stop_entry = 1'b0;
		array_blank = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		// Reset values and read-only places
		rd(OFS_PROT); chk(rdata, 32'ha0);
		rd(OFS_STAT); chk(rdata, 32'hc0);
		wr(OFS_STAT, 32'h4f); rd(OFS_STAT); chk(rdata, 32'hc0);
		wr(OFS_CMD, 32'h41); rd(OFS_CMD); chk(rdata, 32'h0);
		rd(OFS_STAT); chk(rdata, 32'hd0);
		wr(OFS_STAT, 32'h10);
		chk({30'h0, security_state_code}, 32'h3);
		rd(8'hfc); chk({31'h0, rerr}, 32'h1);
		report("reset");
		// Protection may only grow while enabled; debug port overrides
		wr(OFS_PROT, 32'hc0); rd(OFS_PROT); chk(rdata, 32'ha0);
		wr(OFS_PROT, 32'h80); rd(OFS_PROT); chk(rdata, 32'h80);
		dbg(8'h81); rd(OFS_PROT); chk(rdata, 32'h81);
		wr(OFS_PROT, 32'h00); rd(OFS_PROT); chk(rdata, 32'h81);
		dbg(8'h80); rd(OFS_PROT); chk(rdata, 32'h80);
		report("protection");
		// Divider not yet ready, then the error flag only clears on a one
		launch(16'h0100, CMD_BYTE); rd(OFS_STAT); chk(rdata & 32'h10, 32'h10);
		wr(OFS_STAT, 32'h00); rd(OFS_STAT); chk(rdata & 32'h10, 32'h10);
		wr(OFS_STAT, 32'h10); rd(OFS_STAT); chk(rdata & 32'h10, 32'h0);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_STAT, 32'h80); rd(OFS_STAT); chk(rdata & 32'h10, 32'h10);
		wr(OFS_STAT, 32'h30);
		report("access error");
		// Every code, the protection boundary at select 0x40, and the blank result
		for (int i = 0; i < 8; i++) begin
			array_blank <= (i == 1);
			launch(ta[i], tc[i]);
			wait_done(); chk(rdata & 32'h74, te[i]);
			wr(OFS_STAT, 32'h30);
		end
		chk({30'h0, security_state_code}, {30'h0, SEC_UNSECURED});
		rd(OFS_SEC); chk(rdata & 32'h3, {30'h0, SEC_UNSECURED});
		dbg(8'h81);
		launch(16'h0000, CMD_MASS); wait_done(); chk(rdata & 32'h74, 32'h40);
		report("commands");
		// A queued burst fills the buffer; anything else is refused meanwhile
		launch(16'h0100, CMD_BURST);
		launch(16'h0101, CMD_BURST); rd(OFS_STAT); chk(rdata & 32'hc0, 32'h0);
		launch(16'h0100, CMD_PAGE); rd(OFS_STAT); chk(rdata & 32'h10, 32'h10);
		wait_done(); chk(rdata & 32'hc0, 32'hc0);
		wr(OFS_STAT, 32'h30);
		// Buffer empty but array busy: a page erase must still be refused
		launch(16'h0100, CMD_BURST); launch(16'h0100, CMD_PAGE);
		rd(OFS_STAT); chk(rdata & 32'h90, 32'h90);
		wait_done(); wr(OFS_STAT, 32'h30);
		report("burst");
		// Stop in mid-command aborts with an access error
		launch(16'h0100, CMD_BYTE);
		stop_entry <= 1'b1;
		@(posedge pclk);
		stop_entry <= 1'b0;
		wait_done(); chk(rdata & 32'h50, 32'h50);
		wr(OFS_STAT, 32'h30);
		report("stop");
		// Interrupt raised, masked, enabled and cleared
		wr(OFS_ICLR, 32'h7);
		launch(16'h0100, CMD_BYTE); wait_done();
		rd(OFS_ISTAT); chk(rdata & 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IEN, 32'h1); idle(2); chk({31'h0, irq}, 32'h1);
		wr(OFS_ICLR, 32'h1); idle(2); chk({31'h0, irq}, 32'h0);
		rd(OFS_ISTAT); chk(rdata & 32'h1, 32'h0);
		report("interrupt");
		final_report();
	end
endmodule // flash_protect_status_cmd_bench
`default_nettype wire
